// file: hdl/mtc_consts.svh
`ifndef MTC_CONSTS_SVH
`define MTC_CONSTS_SVH

// ==========================================================
// register window offsets (byte offsets, word aligned)
`define MTC_OFF_TX_CONTROL 4'h0
`define MTC_OFF_TX_STATUS 4'h2
`define MTC_OFF_BANK_SELECTOR 4'he

// ==========================================================
// bank selector layout
// signature value is arbitrary, only fixed so host probes can find the window
`define MTC_BANK_SIG_VALUE 8'h5a
`define MTC_BANK_SEL_RESET 3'h0
`define MTC_BANK_SEL_MASK 16'h0007

// ==========================================================
// transmit control field positions
`define MTC_TC_TX_ENABLE 0
`define MTC_TC_LOCAL_LOOP 1
`define MTC_TC_FORCED_COL 2
`define MTC_TC_PAD_EN 7
`define MTC_TC_CRC_SUPPRESS 8
`define MTC_TC_CARRIER_MON 10
`define MTC_TC_FULL_DUPLEX 11
`define MTC_TC_STOP_SQE 12
`define MTC_TC_INT_LOOP 13
`define MTC_TC_WRITE_MASK 16'h3d87
`define MTC_TC_RESET 16'h0000

// ==========================================================
// transmit status field positions
`define MTC_TS_TX_SUCCESS 0
`define MTC_TS_LATE_COL 9
`define MTC_TS_LOST_CARRIER 10
`define MTC_TS_SQE 5
`define MTC_TS_LINK_OK 14
`define MTC_TS_UNDERRUN 15
`define MTC_TS_TX_ENABLE_VIEW 8

// ==========================================================
// framing
`define MTC_MIN_FRAME_BYTES 11'h040
`define MTC_STATUS_DEPTH 16

`endif

// file: hdl/mtc_pkg.sv
package mtc_pkg;

    // host register access, one per cycle
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [1:0] byte_en;
        logic [15:0] wdata;
    } mtc_bus_req_t;

    // transmit engine events reported each cycle
    typedef struct packed {
        logic frame_start;
        logic frame_done;
        logic late_collision;
        logic carrier_lost;
        logic sqe_fail;
        logic underrun;
    } mtc_tx_evt_t;

    // where the serial stream is looped
    typedef enum logic [2:0] {
        MTC_LOOP_NONE,
        MTC_LOOP_PROTOCOL,
        MTC_LOOP_ENCODER_DECODER,
        MTC_LOOP_CABLE,
        MTC_LOOP_DRIVER
    } mtc_loop_t;

endpackage

// file: hdl/mtc_status_mem.sv
`timescale 1ns/10ps

// ==========================================================
// small packet status store, registered read data
module mtc_status_mem
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [15:0] wdata,
    input wire logic [3:0] raddr,
    output logic [15:0] rdata
);

    logic [15:0] mem_q [0:15];

    // write and read on the same edge; read shows old data on a clash
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
        rdata <= mem_q[raddr];
    end

endmodule

// file: hdl/mtc_sync.sv
`timescale 1ns/10ps

// ==========================================================
// two flop level synchroniser
module mtc_sync
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    // first stage only feeds the second
    always_comb
    begin
        meta_d = din;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign dout = sync_q;

endmodule

// file: hdl/mtc_tx_control.sv
`include "mtc_consts.svh"
`timescale 1ns/10ps

module mtc_tx_control
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire mtc_bus_req_t bus_req,
    output logic [15:0] bus_rdata,
    input wire mtc_tx_evt_t tx_evt,
    input wire logic [3:0] pkt_slot,
    input wire logic packet_queued,
    input wire logic aui_select,
    input wire logic link_ok_pin,
    input wire logic link_event_irq_enable,
    input wire logic [3:0] status_raddr,
    output logic [15:0] status_rdata,
    output logic tx_run,
    output logic defer_bypass,
    output logic send_preamble_only,
    output logic send_preamble_sfd,
    output logic append_crc,
    output logic pad_short_frames,
    output logic [10:0] pad_min_bytes,
    output logic carrier_monitor_enable,
    output logic ignore_col_carrier,
    output logic accept_own_frames,
    output logic network_tx_allowed,
    output mtc_loop_t loop_mode,
    output logic link_event
);

    // ==========================================================
    // state
    logic [2:0] bank_sel_q;
    logic [2:0] bank_sel_d;
    logic [15:0] tx_ctrl_q;
    logic [15:0] tx_ctrl_d;
    logic [15:0] tx_stat_q;
    logic [15:0] tx_stat_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic link_prev_q;
    logic link_prev_d;
    logic link_evt_q;
    logic link_evt_d;
    logic in_frame_q;
    logic in_frame_d;
    logic link_sync;
    logic [15:0] live_status;
    logic bank_sel_hit;
    logic bank0_ok;
    logic ctrl_hit;
    logic stat_hit;
    logic tx_enable_set;
    logic fatal_err;
    logic [15:0] wmask;

    // byte enables into a bit mask
    function automatic logic [15:0] lane_mask(input logic [1:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

    // ==========================================================
    // link pin crosses into the clock domain
    mtc_sync u_link_sync
    (
        .clk(clk),
        .reset(reset),
        .din(link_ok_pin),
        .dout(link_sync)
    );

    // ==========================================================
    // address decode
    always_comb
    begin
        bank_sel_hit = (bus_req.addr[3:1] == 3'h7);
        bank0_ok = !bank_sel_q[2] && (bank_sel_q[1:0] == 2'h0);
        ctrl_hit = bank0_ok && (bus_req.addr[3:1] == 3'h0);
        stat_hit = bank0_ok && (bus_req.addr[3:1] == 3'h1);
        wmask = lane_mask(bus_req.byte_en);
    end

    // ==========================================================
    // bank selector and transmit control
    always_comb
    begin
        bank_sel_d = bank_sel_q;
        tx_ctrl_d = tx_ctrl_q;
        tx_enable_set = 1'b0;
        fatal_err = tx_evt.late_collision || tx_evt.underrun
            || (tx_evt.carrier_lost && tx_ctrl_q[`MTC_TC_CARRIER_MON])
            || (tx_evt.sqe_fail && tx_ctrl_q[`MTC_TC_STOP_SQE]);
        if (bus_req.wr && bank_sel_hit && bus_req.byte_en[0])
        begin
            bank_sel_d = bus_req.wdata[2:0];
        end
        if (bus_req.wr && ctrl_hit)
        begin
            // only implemented bits take writes
            tx_ctrl_d = (tx_ctrl_q & ~(wmask & `MTC_TC_WRITE_MASK))
                | (bus_req.wdata & wmask & `MTC_TC_WRITE_MASK);
            tx_enable_set = bus_req.byte_en[0] && bus_req.wdata[`MTC_TC_TX_ENABLE]
                && !tx_ctrl_q[`MTC_TC_TX_ENABLE];
        end
        // hardware clear loses to nothing but a fresh host set
        if (fatal_err && !tx_enable_set)
        begin
            tx_ctrl_d[`MTC_TC_TX_ENABLE] = 1'b0;
        end
    end

    // ==========================================================
    // frame tracking and transmit status
    always_comb
    begin
        in_frame_d = in_frame_q;
        tx_stat_d = tx_stat_q;
        if (tx_evt.frame_start)
        begin
            in_frame_d = 1'b1;
            tx_stat_d[`MTC_TS_TX_SUCCESS] = 1'b0;
        end
        if (tx_evt.frame_done)
        begin
            in_frame_d = 1'b0;
            tx_stat_d[`MTC_TS_TX_SUCCESS] = !fatal_err;
        end
        // host set of enable clears error history first, events win after
        if (tx_enable_set)
        begin
            tx_stat_d[`MTC_TS_UNDERRUN] = 1'b0;
            tx_stat_d[`MTC_TS_LATE_COL] = 1'b0;
            tx_stat_d[`MTC_TS_LOST_CARRIER] = 1'b0;
            tx_stat_d[`MTC_TS_SQE] = 1'b0;
            tx_stat_d[`MTC_TS_TX_SUCCESS] = 1'b0;
        end
        if (tx_evt.underrun)
        begin
            tx_stat_d[`MTC_TS_UNDERRUN] = 1'b1;
        end
        if (tx_evt.late_collision)
        begin
            tx_stat_d[`MTC_TS_LATE_COL] = 1'b1;
        end
        if (tx_evt.carrier_lost && tx_ctrl_q[`MTC_TC_CARRIER_MON])
        begin
            tx_stat_d[`MTC_TS_LOST_CARRIER] = 1'b1;
        end
        if (tx_evt.sqe_fail)
        begin
            tx_stat_d[`MTC_TS_SQE] = 1'b1;
        end
    end

    // live bits merged over the held completion status
    always_comb
    begin
        live_status = tx_stat_q;
        live_status[`MTC_TS_LINK_OK] = link_sync;
        live_status[`MTC_TS_TX_ENABLE_VIEW] = tx_ctrl_q[`MTC_TC_TX_ENABLE];
    end

    // ==========================================================
    // link change event
    always_comb
    begin
        link_prev_d = link_sync;
        link_evt_d = (link_sync != link_prev_q) && link_event_irq_enable;
    end

    // ==========================================================
    // read data, registered
    always_comb
    begin
        rdata_d = rdata_q;
        if (bus_req.rd)
        begin
            if (bank_sel_hit)
            begin
                rdata_d = {`MTC_BANK_SIG_VALUE, 5'h00, bank_sel_q};
            end
            else if (ctrl_hit)
            begin
                rdata_d = tx_ctrl_q;
            end
            else if (stat_hit)
            begin
                rdata_d = live_status;
            end
            else
            begin
                rdata_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            bank_sel_q <= `MTC_BANK_SEL_RESET;
            tx_ctrl_q <= `MTC_TC_RESET;
            tx_stat_q <= 16'h0000;
            rdata_q <= 16'h0000;
            link_prev_q <= 1'b0;
            link_evt_q <= 1'b0;
            in_frame_q <= 1'b0;
        end
        else
        begin
            bank_sel_q <= bank_sel_d;
            tx_ctrl_q <= tx_ctrl_d;
            tx_stat_q <= tx_stat_d;
            rdata_q <= rdata_d;
            link_prev_q <= link_prev_d;
            link_evt_q <= link_evt_d;
            in_frame_q <= in_frame_d;
        end
    end

    // ==========================================================
    // completion status written into the packet's slot
    mtc_status_mem u_status_mem
    (
        .clk(clk),
        .we(tx_evt.frame_done),
        .waddr(pkt_slot),
        .wdata(tx_stat_d),
        .raddr(status_raddr),
        .rdata(status_rdata)
    );

    // ==========================================================
    // loopback mode decode, highest priority first
    always_comb
    begin
        if (tx_ctrl_q[`MTC_TC_INT_LOOP])
        begin
            loop_mode = MTC_LOOP_PROTOCOL;
        end
        else if (tx_ctrl_q[`MTC_TC_LOCAL_LOOP] && tx_ctrl_q[`MTC_TC_FULL_DUPLEX])
        begin
            loop_mode = MTC_LOOP_ENCODER_DECODER;
        end
        else if (!tx_ctrl_q[`MTC_TC_LOCAL_LOOP] && tx_ctrl_q[`MTC_TC_FULL_DUPLEX])
        begin
            loop_mode = aui_select ? MTC_LOOP_CABLE : MTC_LOOP_DRIVER;
        end
        else
        begin
            loop_mode = MTC_LOOP_NONE;
        end
    end

    // ==========================================================
    // transmit engine steering
    assign bus_rdata = rdata_q;
    // a frame under way finishes even after enable drops
    assign tx_run = tx_ctrl_q[`MTC_TC_TX_ENABLE] || in_frame_q;
    assign defer_bypass = tx_ctrl_q[`MTC_TC_FORCED_COL];
    assign send_preamble_only = tx_ctrl_q[`MTC_TC_FORCED_COL]
        && tx_ctrl_q[`MTC_TC_TX_ENABLE] && !packet_queued;
    assign send_preamble_sfd = tx_ctrl_q[`MTC_TC_FORCED_COL]
        && tx_ctrl_q[`MTC_TC_TX_ENABLE] && packet_queued;
    assign append_crc = !tx_ctrl_q[`MTC_TC_CRC_SUPPRESS];
    assign pad_short_frames = tx_ctrl_q[`MTC_TC_PAD_EN];
    assign pad_min_bytes = `MTC_MIN_FRAME_BYTES;
    assign carrier_monitor_enable = tx_ctrl_q[`MTC_TC_CARRIER_MON]
        && !tx_ctrl_q[`MTC_TC_LOCAL_LOOP];
    assign ignore_col_carrier = tx_ctrl_q[`MTC_TC_LOCAL_LOOP];
    assign accept_own_frames = tx_ctrl_q[`MTC_TC_FULL_DUPLEX];
    assign network_tx_allowed = !tx_ctrl_q[`MTC_TC_INT_LOOP]
        && !tx_ctrl_q[`MTC_TC_LOCAL_LOOP];
    assign link_event = link_evt_q;

endmodule

// file: dv/mtc_tx_engine_model.sv
`timescale 1ns/10ps

// ==========
// transmit engine stand-in: one event pulse, prompt or late
module mtc_tx_engine_model
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [1:0] delay,
    output mtc_tx_evt_t evt
);
    logic [1:0] cnt_q;
    logic [2:0] kind_q;
    logic busy_q;

    // pulses last one cycle only, as the control block expects
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            evt <= '0;
            busy_q <= 1'b0;
            cnt_q <= 2'h0;
            kind_q <= 3'h0;
        end
        else
        begin
            evt <= '0;
            if (go)
            begin
                busy_q <= 1'b1;
                cnt_q <= delay;
                kind_q <= kind;
            end
            else if (busy_q && cnt_q == 2'h0)
            begin
                evt <= mtc_tx_evt_t'(6'h01 << kind_q);
                busy_q <= 1'b0;
            end
            else if (busy_q)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule

// file: dv/mtc_tx_control_properties.sv
`timescale 1ns/10ps

// ==========
// port checks for the bank select and transmit control block
module mtc_tx_control_properties
    import mtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire mtc_bus_req_t bus_req,
    input wire logic [15:0] bus_rdata,
    input wire logic append_crc,
    input wire logic pad_short_frames,
    input wire logic network_tx_allowed,
    input wire mtc_loop_t loop_mode,
    input wire logic link_event,
    input wire logic link_event_irq_enable
);
    logic [2:0] bank_q;
    logic sel_rd;
    logic sel_wr;
    logic ctl_wr;

    // decode of the three accesses that matter here
    assign sel_rd = bus_req.rd && bus_req.addr[3:1] == 3'h7;
    assign sel_wr = bus_req.wr && bus_req.addr[3:1] == 3'h7 && bus_req.byte_en[0];
    assign ctl_wr = bus_req.wr && bus_req.addr[3:1] == 3'h0 && bus_req.byte_en == 2'b11;

    // own copy of the bank so refusals can be judged
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            bank_q <= 3'h0;
        else if (sel_wr)
            bank_q <= bus_req.wdata[2:0];
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sig_read_a: assert property (sel_rd |=> bus_rdata[15:8] == 8'h5a)
        else $error("bank selector signature wrong");
    bank_read_a: assert property (sel_rd && !sel_wr |=> bus_rdata[7:0] == {5'h0, bank_q})
        else $error("bank selector low byte wrong");
    ctl_ignore_a: assert property (ctl_wr && bank_q[2] |=> $stable(append_crc))
        else $error("control changed in a missing bank");
    crc_follow_a: assert property (ctl_wr && bank_q == 3'h0 |=>
        append_crc != $past(bus_req.wdata[8]))
        else $error("crc append does not follow control");
    pad_follow_a: assert property (ctl_wr && bank_q == 3'h0 |=>
        pad_short_frames == $past(bus_req.wdata[7]))
        else $error("padding does not follow control");
    int_loop_a: assert property (ctl_wr && bank_q == 3'h0 && bus_req.wdata[13] |=>
        loop_mode == MTC_LOOP_PROTOCOL && !network_tx_allowed)
        else $error("internal loop not taken");
    local_loop_a: assert property (ctl_wr && bank_q == 3'h0 && bus_req.wdata[1] |=>
        !network_tx_allowed)
        else $error("local loop still sends");
    link_gate_a: assert property (link_event |-> $past(link_event_irq_enable))
        else $error("link event while disabled");

    cover property (link_event);
    cover property (ctl_wr && bank_q[2]);
    cover property (sel_rd);
endmodule

bind mtc_tx_control mtc_tx_control_properties chk_i (.*);

// file: dv/mac_tx_control_bank_select_bench.sv
`timescale 1ns/10ps

// ==========
// bench for the bank select and transmit control block
module mac_tx_control_bank_select_bench
    import mtc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    mtc_bus_req_t bus_req = '0;
    logic [15:0] rdata;
    mtc_tx_evt_t evt;
    logic go = 1'b0;
    logic [2:0] kind = 3'h0;
    logic [1:0] dly = 2'h0;
    logic queued = 1'b0;
    logic aui = 1'b0;
    logic link_pin = 1'b0;
    logic link_ie = 1'b0;
    logic [3:0] slot = 4'h0;
    logic [3:0] sraddr = 4'h0;
    logic [15:0] srdata;
    logic [10:0] padmin;
    logic igncc;
    logic tx_run, bypass, pre_only, pre_sfd, crc, pad, cmon, own, net_ok, link_ev;
    mtc_loop_t loop_mode;
    logic rd_d = 1'b0;
    logic [15:0] exp_q[$];
    int tests_run = 0;
    int mismatches = 0;
    integer seed = 32'hca90b603;

    always #10 clk = ~clk;

    mtc_tx_control dut (.clk(clk), .reset(reset), .bus_req(bus_req), .bus_rdata(rdata),
        .tx_evt(evt), .pkt_slot(slot), .packet_queued(queued), .aui_select(aui),
        .link_ok_pin(link_pin), .link_event_irq_enable(link_ie), .status_raddr(sraddr),
        .status_rdata(srdata), .tx_run(tx_run), .defer_bypass(bypass),
        .send_preamble_only(pre_only), .send_preamble_sfd(pre_sfd), .append_crc(crc),
        .pad_short_frames(pad), .pad_min_bytes(padmin), .carrier_monitor_enable(cmon),
        .ignore_col_carrier(igncc), .accept_own_frames(own), .network_tx_allowed(net_ok),
        .loop_mode(loop_mode), .link_event(link_ev));

    mtc_tx_engine_model eng (.clk(clk), .reset(reset), .go(go), .kind(kind), .delay(dly),
        .evt(evt));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // one request cycle, then an idle cycle so strobes never merge
    task automatic bus(input logic r, input logic [3:0] a, input logic [1:0] be,
        input logic [15:0] d);
        @(posedge clk);
        bus_req <= {r, !r, a, be, d};
        @(posedge clk);
        bus_req <= '0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        bus(1'b1, a, 2'b11, 16'h0);
    endtask

    // random delay makes the engine answer promptly or late
    task automatic fire(input logic [2:0] k);
        @(posedge clk);
        go <= 1'b1;
        kind <= k;
        dly <= 2'($random(seed));
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // read answers land one cycle after the request edge
    always @(posedge clk)
        rd_d <= bus_req.rd;
    always @(negedge clk)
    begin
        if (rd_d)
            chk("bus_rdata", exp_q.pop_front(), rdata);
    end

    // hang guard, far beyond the few hundred cycles needed
    initial
    begin
        #400000;
        mismatches++;
        print_verdict();
    end

    initial
    begin : main
        logic [15:0] v;
        int n;
        logic [15:0] ctl [4] = '{16'h0001, 16'h0005, 16'h1001, 16'h0401};
        logic [2:0] knd [4] = '{3'h0, 3'h3, 3'h1, 3'h2};
        logic [15:0] st [4] = '{16'h8000, 16'h0200, 16'h0020, 16'h0400};
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rd(4'he, 16'h5a00);
        chk("append_crc", 16'h1, crc);
        chk("pad_min", 16'h0040, 16'(padmin));
        for (int b = 1; b < 8; b++)
        begin
            bus(1'b0, 4'he, 2'b01, 16'(b));
            rd(4'he, 16'h5a00 | 16'(b));
            rd(4'h0, 16'h0);
            bus(1'b0, 4'h0, 2'b11, 16'hffff);
        end
        bus(1'b0, 4'he, 2'b01, 16'h0);
        rd(4'h0, 16'h0);
        bus(1'b0, 4'h0, 2'b01, 16'hffff);
        rd(4'h0, 16'h0087);
        // random control words, loop bit kept with full duplex
        repeat (6)
        begin
            v = 16'($random(seed));
            v[11] = v[11] | v[1];
            bus(1'b0, 4'h0, 2'b11, v);
            aui <= v[15];
            #1;
            chk("append_crc", 16'(!v[8]), crc);
            chk("pad", 16'(v[7]), pad);
            // local loop ignores carrier, so monitoring is masked there
            chk("carrier_mon", 16'(v[10] & !v[1]), cmon);
            chk("ignore_col", 16'(v[1]), igncc);
            chk("accept_own", 16'(v[11]), own);
            chk("net_ok", 16'(!(v[13] | v[1])), net_ok);
            chk("loop_mode", v[13] ? MTC_LOOP_PROTOCOL : v[1] ? MTC_LOOP_ENCODER_DECODER : v[11] ?
                (v[15] ? MTC_LOOP_CABLE : MTC_LOOP_DRIVER) : MTC_LOOP_NONE, loop_mode);
            rd(4'h0, v & 16'h3d87);
        end
        // each fatal event drops enable; re-enabling clears its flag
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 4'h0, 2'b11, ctl[i]);
            fire(knd[i]);
            rd(4'h0, ctl[i] & 16'hfffe);
            rd(4'h2, st[i]);
            bus(1'b0, 4'h0, 2'b11, ctl[i]);
            rd(4'h2, 16'h0100);
        end
        link_ie <= 1'b1;
        link_pin <= 1'b1;
        n = 0;
        repeat (8)
        begin
            @(negedge clk);
            n += int'(link_ev);
        end
        chk("link_event", 16'h1, 16'(n));
        rd(4'h2, 16'h4100);
        bus(1'b0, 4'h0, 2'b11, 16'h0005);
        queued <= 1'b0;
        #1;
        chk("defer_bypass", 16'h1, bypass);
        chk("pre_only", 16'h1, pre_only);
        @(posedge clk);
        queued <= 1'b1;
        #1;
        chk("pre_sfd", 16'h1, pre_sfd);
        chk("pre_only", 16'h0, pre_only);
        fire(3'h5);
        bus(1'b0, 4'h0, 2'b11, 16'h0004);
        slot <= 4'h5;
        #1;
        chk("tx_run", 16'h1, tx_run);
        fire(3'h4);
        sraddr <= 4'h5;
        #1;
        chk("tx_run", 16'h0, tx_run);
        // clean completion stores only the success flag in its slot
        repeat (2) @(posedge clk);
        #1;
        chk("status_store", 16'h0001, srdata);
        print_verdict();
    end
endmodule
